// *** src/dtc_cutoff.sv ***
// Dual channel hardwired torque cutoff supervisor, one clock, plain ports
// Safety inputs are high while current flows; inputs synchronous to clk
// Expects the host controlword, utility flag and power status as plain levels
// Motor power, brake and ready outputs are registered, one cycle behind state
`include "dtc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dtc_cutoff #(
	parameter int unsigned MISMATCH_CYC = `DTC_MISMATCH_CYC, // Shorten for simulation
	parameter int unsigned OFF_MAX_CYC = `DTC_OFF_MAX_CYC // Response bound, checked only
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic safety_request_a, // High when current flows
	input wire logic safety_request_b,
	input wire logic [3:0] controlword_cmd, // Controlword bits 3..0
	input wire logic main_power_on,
	input wire logic utility_active, // Any self-enabling utility running
	input wire logic drive_fault, // Other drive faults
	input wire logic alarm_clear,
	input wire logic [3:0] stop_method_setting,
	input wire logic brake_hold_req, // Normal brake sequencing from the servo logic
	output logic motor_power_en,
	output logic [3:0] stop_mode_out,
	output logic drive_ready_out,
	output logic brake_release_out,
	output logic fault_out,
	output logic feedback_monitor_out,
	output logic channel_mismatch_alarm,
	output logic mon_request_a,
	output logic mon_request_b,
	output logic cutoff_active
);
	localparam logic [15:0] FILT_CYC = 16'(`DTC_FILTER_CYC); // 0.5 ms in cycles
	localparam logic [31:0] MIS_CYC = 32'(MISMATCH_CYC);

	// Passes an OFF only once it outlasts the filter interval
	function automatic logic filt_next(input logic raw, input logic cur, input logic [15:0] cnt);
		filt_next = raw ? 1'b1 : ((cnt >= FILT_CYC) ? 1'b0 : cur);
	endfunction

	logic fa_r, fb_r; // Filtered channel levels
	logic [15:0] ca_r, cb_r; // OFF run-length counters
	logic [31:0] mis_cnt_r;
	logic mis_r;
	logic shut_seen_r; // Shutdown seen since the cutoff hit
	logic util_block_r; // Utility must be left before restart
	dtc_pkg::dtc_state_t state_r;
	logic both_on, both_off, cw_shut, cw_en;

	assign both_on = fa_r & fb_r;
	assign both_off = ~fa_r & ~fb_r;
	assign cw_shut = (controlword_cmd & `DTC_CW_MASK) == `DTC_CW_SHUTDOWN;
	assign cw_en = (controlword_cmd & `DTC_CW_MASK_EN) == `DTC_CW_ENABLE;

	// OFF pulse filters; an ON level passes through at once, the safe direction being OFF
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fa_r <= 1'b0;
			fb_r <= 1'b0;
			ca_r <= 16'h0000;
			cb_r <= 16'h0000;
		end else begin
			ca_r <= safety_request_a ? 16'h0000 : ((ca_r >= FILT_CYC) ? ca_r : ca_r + 16'h0001);
			cb_r <= safety_request_b ? 16'h0000 : ((cb_r >= FILT_CYC) ? cb_r : cb_r + 16'h0001);
			fa_r <= filt_next(safety_request_a, fa_r, ca_r);
			fb_r <= filt_next(safety_request_b, fb_r, cb_r);
		end
	end

	// Channel disagreement timer and latched alarm; the set wins over a clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mis_cnt_r <= 32'h0000_0000;
			mis_r <= 1'b0;
		end else begin
			mis_cnt_r <= (fa_r ^ fb_r) ? ((mis_cnt_r >= MIS_CYC) ? mis_cnt_r : mis_cnt_r + 32'h1) : 32'h0;
			if ((fa_r ^ fb_r) && mis_cnt_r >= MIS_CYC) begin
				mis_r <= 1'b1;
			end else if (alarm_clear && !(fa_r ^ fb_r)) begin
				mis_r <= 1'b0;
			end
		end
	end

	// Recovery qualifiers: shutdown seen, utility ended and entered anew
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shut_seen_r <= 1'b0;
			util_block_r <= 1'b0;
		end else begin
			if (state_r == dtc_pkg::DTC_CUTOFF && !both_on) begin
				shut_seen_r <= 1'b0;
			end else if (cw_shut) begin
				shut_seen_r <= 1'b1;
			end
			if (state_r == dtc_pkg::DTC_RUN && !both_on && utility_active) begin
				util_block_r <= 1'b1;
			end else if (!utility_active) begin
				util_block_r <= 1'b0;
			end
		end
	end

	// Main sequence: cutoff, torque-off idle, powered run
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= dtc_pkg::DTC_CUTOFF;
		end else begin
			unique case (state_r)
				dtc_pkg::DTC_CUTOFF: begin
					// A pending enable holds the cutoff; leaving needs no enable held
					if (both_on && !mis_r && !cw_en && !utility_active
						&& (main_power_on || shut_seen_r)) begin
						state_r <= dtc_pkg::DTC_IDLE;
					end
				end
				dtc_pkg::DTC_IDLE: begin
					if (!both_on || mis_r) begin
						state_r <= dtc_pkg::DTC_CUTOFF;
					end else if (!main_power_on && !shut_seen_r) begin
						state_r <= dtc_pkg::DTC_CUTOFF;
					end else if ((cw_en && shut_seen_r) || (utility_active && !util_block_r)) begin
						state_r <= dtc_pkg::DTC_RUN;
					end
				end
				dtc_pkg::DTC_RUN: begin
					if (!both_on || mis_r) begin
						state_r <= dtc_pkg::DTC_CUTOFF;
					end else if (cw_shut) begin
						state_r <= dtc_pkg::DTC_IDLE;
					end
				end
			endcase
		end
	end

	// Registered outputs; power drops in the cycle after the filtered OFF
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			motor_power_en <= 1'b0;
			stop_mode_out <= 4'h0;
			drive_ready_out <= 1'b0;
			brake_release_out <= 1'b0;
			fault_out <= 1'b0;
			feedback_monitor_out <= 1'b0;
			channel_mismatch_alarm <= 1'b0;
			mon_request_a <= 1'b0;
			mon_request_b <= 1'b0;
			cutoff_active <= 1'b1;
		end else begin
			motor_power_en <= state_r == dtc_pkg::DTC_RUN && both_on && !mis_r;
			stop_mode_out <= stop_method_setting;
			drive_ready_out <= state_r == dtc_pkg::DTC_IDLE && both_on;
			// Brake delay is bypassed by dropping straight on cutoff
			brake_release_out <= state_r == dtc_pkg::DTC_RUN && both_on && !brake_hold_req;
			fault_out <= (drive_fault || mis_r) && state_r != dtc_pkg::DTC_CUTOFF;
			feedback_monitor_out <= both_off;
			channel_mismatch_alarm <= mis_r;
			mon_request_a <= fa_r;
			mon_request_b <= fb_r;
			cutoff_active <= state_r == dtc_pkg::DTC_CUTOFF;
		end
	end

	// Checks
	// Properties look at internal state, registered outputs and module inputs
	// Where an output is compared with an earlier value, the attempt starts
	// one edge after reset, except in a_mon_follow, so that the reset values
	// are never compared with a pre-release sample

	// Run length of both raw inputs OFF, used only by the response-time check
	// A counter is used because the bound is far beyond a delay range
	logic [31:0] off_run_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			off_run_r <= 32'h0000_0000;
		end else if (safety_request_a || safety_request_b) begin
			// Any current flowing restarts the measurement
			off_run_r <= 32'h0000_0000;
		end else if (off_run_r < OFF_MAX_CYC) begin
			// Saturates at the bound so it cannot wrap
			off_run_r <= off_run_r + 32'h0000_0001;
		end
	end
	a_power_off_bound: assert property (@(posedge clk) disable iff (!rst_b)
		off_run_r >= OFF_MAX_CYC |-> !motor_power_en)
		else $error("motor power not removed");
	// Power only follows a run state
	a_power_run_only: assert property (@(posedge clk) disable iff (!rst_b)
		motor_power_en |-> $past(state_r) == dtc_pkg::DTC_RUN)
		else $error("power outside run");
	// Ready stays low while the cutoff holds
	a_ready_refuse: assert property (@(posedge clk) disable iff (!rst_b)
		$past(state_r) == dtc_pkg::DTC_CUTOFF |-> !drive_ready_out)
		else $error("ready in cutoff");
	// Brake release only in run and when the servo logic allows it
	a_brake_run_only: assert property (@(posedge clk) disable iff (!rst_b)
		brake_release_out |-> $past(state_r) == dtc_pkg::DTC_RUN && !$past(brake_hold_req))
		else $error("brake released outside run");
	// Stop mode is a straight registered copy of the setting
	a_stop_copy: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> stop_mode_out == $past(stop_method_setting))
		else $error("stop mode not copied");
	// Timer expiry with channels apart must latch the alarm
	a_mis_set: assert property (@(posedge clk) disable iff (!rst_b)
		(fa_r ^ fb_r) && mis_cnt_r >= MIS_CYC |=> mis_r)
		else $error("mismatch not raised");
	// Cutoff is kept unless both channels are on with no enable, utility or alarm
	a_recover_gate: assert property (@(posedge clk) disable iff (!rst_b)
		state_r == dtc_pkg::DTC_CUTOFF && !(both_on && !cw_en && !utility_active && !mis_r)
		|=> state_r == dtc_pkg::DTC_CUTOFF)
		else $error("left cutoff early");
	// Without main power a shutdown is needed to leave cutoff
	a_main_power_hold: assert property (@(posedge clk) disable iff (!rst_b)
		state_r == dtc_pkg::DTC_CUTOFF && !main_power_on && !shut_seen_r
		|=> state_r == dtc_pkg::DTC_CUTOFF)
		else $error("left cutoff without shutdown");
	// Enable alone cannot start the motor before a shutdown
	a_enable_needs_shut: assert property (@(posedge clk) disable iff (!rst_b)
		state_r == dtc_pkg::DTC_IDLE && !utility_active && !shut_seen_r
		|=> state_r != dtc_pkg::DTC_RUN)
		else $error("run without shutdown");
	// A blocked utility cannot restart the motor by itself
	a_util_block: assert property (@(posedge clk) disable iff (!rst_b)
		state_r == dtc_pkg::DTC_IDLE && util_block_r && !(cw_en && shut_seen_r)
		|=> state_r != dtc_pkg::DTC_RUN)
		else $error("utility restarted");
	// Loss of either filtered channel forces cutoff
	a_cutoff_entry: assert property (@(posedge clk) disable iff (!rst_b)
		state_r != dtc_pkg::DTC_CUTOFF && !both_on |=> state_r == dtc_pkg::DTC_CUTOFF)
		else $error("cutoff not entered");
	// Channel a status display follows its filter
	a_mon_a_follow: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> mon_request_a == $past(fa_r))
		else $error("monitor a stale");
	// A latched alarm keeps the motor unpowered
	a_mis_no_power: assert property (@(posedge clk) disable iff (!rst_b)
		mis_r |=> !motor_power_en)
		else $error("power with alarm");
	a_ready_cond: assert property (@(posedge clk) disable iff (!rst_b)
		drive_ready_out |-> $past(state_r) == dtc_pkg::DTC_IDLE && $past(both_on))
		else $error("ready without idle");
	a_fault_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		$past(state_r) == dtc_pkg::DTC_CUTOFF |-> !fault_out)
		else $error("fault in cutoff");
	a_edm_map: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> feedback_monitor_out == $past(both_off))
		else $error("feedback monitor mismatch");
	a_brake_drop: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(both_on) |=> !brake_release_out)
		else $error("brake not dropped");
	a_filter_short: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(safety_request_a) && ca_r < FILT_CYC && fa_r |-> ##1 fa_r)
		else $error("short pulse seen");
	a_alarm_hold: assert property (@(posedge clk) disable iff (!rst_b)
		mis_r && !alarm_clear |=> mis_r)
		else $error("alarm dropped");
	a_cutoff_enable: assert property (@(posedge clk) disable iff (!rst_b)
		state_r == dtc_pkg::DTC_CUTOFF |=> state_r != dtc_pkg::DTC_RUN)
		else $error("run from cutoff");
	a_mon_follow: assert property (@(posedge clk) disable iff (!rst_b)
		mon_request_b == $past(fb_r))
		else $error("monitor stale");
	c_run: cover property (@(posedge clk) disable iff (!rst_b) $rose(motor_power_en));
	c_cutoff: cover property (@(posedge clk) disable iff (!rst_b) $fell(motor_power_en));
	c_mismatch: cover property (@(posedge clk) disable iff (!rst_b) $rose(channel_mismatch_alarm));
	c_ready: cover property (@(posedge clk) disable iff (!rst_b) $rose(drive_ready_out));
	// Utility start from idle, the host-free path
	c_utility_run: cover property (@(posedge clk) disable iff (!rst_b)
		state_r == dtc_pkg::DTC_IDLE && utility_active ##1 state_r == dtc_pkg::DTC_RUN);
endmodule
`default_nettype wire

// *** src/dtc_pkg.sv ***
// Types for the dual channel torque cutoff supervisor
// No timing or offsets here; those live in dtc_regs.svh
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_CUTOFF,
		DTC_IDLE,
		DTC_RUN
	} dtc_state_t;
endpackage

// *** src/dtc_regs.svh ***
// Timing constants and encodings for the dual channel torque cutoff supervisor
// Assumes a 40 MHz clock on clk
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH
`define DTC_CLK_HZ 40000000
`define DTC_FILTER_US 500
`define DTC_FILTER_CYC (`DTC_FILTER_US * (`DTC_CLK_HZ / 1000000))
`define DTC_OFF_MAX_MS 8
`define DTC_OFF_MAX_CYC (`DTC_OFF_MAX_MS * (`DTC_CLK_HZ / 1000))
`define DTC_MISMATCH_S 10
`define DTC_MISMATCH_CYC (`DTC_MISMATCH_S * `DTC_CLK_HZ)
`define DTC_CW_SHUTDOWN 4'h6
`define DTC_CW_ENABLE 4'hf
`define DTC_CW_MASK 4'h7
`define DTC_CW_MASK_EN 4'hf
`endif

// *** verification/dtc_safety_unit.sv ***
// Model of the external safety unit feeding both request channels
// Assumes guard and fault inputs change away from the rising edge
`timescale 1ns/1ps
`default_nettype none
module dtc_safety_unit (
	input wire logic clk,
	input wire logic guard_open, // Guard opened by operator
	input wire logic fail_a, // Injected loss of current on channel a
	input wire logic feedback_monitor_out,
	output logic safety_request_a,
	output logic safety_request_b
);
	logic armed_r; // Unit reset, both relays closed
	initial armed_r = 1'b0;
	// Reset is refused while feedback is off, so a stuck channel blocks restart
	always @(posedge clk) begin
		if (guard_open) begin
			armed_r <= 1'b0;
		end else if (feedback_monitor_out) begin
			armed_r <= 1'b1;
		end
	end
	assign safety_request_a = armed_r & ~fail_a;
	assign safety_request_b = armed_r;
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the torque cutoff supervisor
// Assumes the safety unit model drives the request channels
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, rst_b, main_power_on, utility_active, drive_fault, alarm_clear, brake_hold_req;
	logic guard_open, fail_a, sa, sb, fb;
	logic [3:0] cmd, stop_set;
	int miscompares = 0, cmp_count = 0, seed = 56, m_st = 0; // m_st: 0 cutoff, 1 idle, 2 run
	dtc_safety_unit unit (.clk(clk), .guard_open(guard_open), .fail_a(fail_a),
		.feedback_monitor_out(fb), .safety_request_a(sa), .safety_request_b(sb));
	dtc_cutoff #(.MISMATCH_CYC(200)) dut (.clk(clk), .rst_b(rst_b), .safety_request_a(sa),
		.safety_request_b(sb), .controlword_cmd(cmd), .main_power_on(main_power_on),
		.utility_active(utility_active), .drive_fault(drive_fault), .alarm_clear(alarm_clear),
		.stop_method_setting(stop_set), .brake_hold_req(brake_hold_req), .motor_power_en(),
		.stop_mode_out(), .drive_ready_out(), .brake_release_out(), .fault_out(),
		.feedback_monitor_out(fb), .channel_mismatch_alarm(), .mon_request_a(), .mon_request_b(),
		.cutoff_active());
	// Free running 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Bounded wait for the cutoff flag to reach a level
	task automatic wait_cut(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && dut.cutoff_active !== v; i++) cyc(1);
		if (i == lim) begin
			miscompares++;
			final_report();
		end
	endtask
	// Compare every output except stop_mode_out and channel_mismatch_alarm with the model state
	task automatic chk_all();
		chk(dut.motor_power_en, m_st == 2);
		chk(dut.drive_ready_out, m_st == 1);
		chk(dut.brake_release_out, m_st == 2);
		chk(dut.cutoff_active, m_st == 0);
		chk(dut.fault_out, 1'b0);
		chk(fb, !sa && !sb);
		chk(dut.mon_request_a, sa);
		chk(dut.mon_request_b, sb);
	endtask
	initial begin
		{rst_b, utility_active, drive_fault, alarm_clear, brake_hold_req, guard_open, fail_a} = 7'h00;
		main_power_on = 1'b1;
		cmd = 4'h0;
		stop_set = 4'h0;
		repeat (2) @(posedge clk);
		cyc(1);
		rst_b = 1'b1;
		cmd = 4'hf;
		cyc(30);
		chk(dut.drive_ready_out, 1'b0);
		chk(dut.cutoff_active, 1'b1);
		cmd = 4'h0;
		wait_cut(1'b0, 100);
		m_st = 1;
		cyc(3);
		chk_all();
		$display("test recover done");
		cmd = 4'h6;
		cyc(4);
		cmd = 4'hf;
		stop_set = 4'($random(seed));
		cyc(4);
		m_st = 2;
		chk_all();
		chk(dut.stop_mode_out, stop_set);
		fail_a = 1'b1;
		cyc(100);
		fail_a = 1'b0;
		cyc(4);
		chk_all();
		$display("test run and glitch done");
		guard_open = 1'b1;
		drive_fault = 1'b1;
		wait_cut(1'b1, 20100);
		m_st = 0;
		cyc(3);
		chk_all();
		{guard_open, drive_fault, cmd} = 6'h00;
		wait_cut(1'b0, 100);
		m_st = 1;
		cyc(3);
		chk_all();
		$display("test cutoff done");
		fail_a = 1'b1;
		wait_cut(1'b1, 20500);
		m_st = 0;
		cyc(210);
		chk(dut.channel_mismatch_alarm, 1'b1);
		chk_all();
		fail_a = 1'b0;
		cyc(4);
		chk(dut.cutoff_active, 1'b1);
		alarm_clear = 1'b1;
		cyc(4);
		alarm_clear = 1'b0;
		chk(dut.channel_mismatch_alarm, 1'b0);
		utility_active = 1'b1;
		cyc(4);
		chk(dut.motor_power_en, 1'b1);
		$display("test mismatch done");
		final_report();
	end
endmodule
`default_nettype wire
